// ---- hw/cod_pkg.sv ----
package cod_pkg;
    // operation field values
    localparam logic [2:0] OP_ADD = 3'h0;
    localparam logic [2:0] OP_ADC = 3'h1;
    localparam logic [2:0] OP_SUB = 3'h2;
    localparam logic [2:0] OP_SBW = 3'h3;
    localparam logic [2:0] OP_AND = 3'h4;
    localparam logic [2:0] OP_XOR = 3'h5;
    localparam logic [2:0] OP_OR  = 3'h6;
    localparam logic [2:0] OP_CPA = 3'h7;
    // register select field values
    localparam logic [2:0] REG_B   = 3'h0;
    localparam logic [2:0] REG_C   = 3'h1;
    localparam logic [2:0] REG_D   = 3'h2;
    localparam logic [2:0] REG_E   = 3'h3;
    localparam logic [2:0] REG_H   = 3'h4;
    localparam logic [2:0] REG_L   = 3'h5;
    localparam logic [2:0] REG_MEM = 3'h6;
    localparam logic [2:0] REG_A   = 3'h7;
    // pair field values
    localparam logic [1:0] PAIR_BC = 2'h0;
    localparam logic [1:0] PAIR_DE = 2'h1;
    localparam logic [1:0] PAIR_HL = 2'h2;
    localparam logic [1:0] PAIR_SP = 2'h3;
    // opcode patterns
    localparam logic [1:0] PFX_ALU_REG = 2'h2;
    localparam logic [1:0] PFX_HI      = 2'h3;
    localparam logic [1:0] PFX_LO      = 2'h0;
    localparam logic [2:0] LOW_IMM     = 3'h6;
    localparam logic [3:0] LOW_PLD     = 4'h1;
    localparam logic [3:0] LOW_PUSH    = 4'h5;
    localparam logic [3:0] LOW_POP     = 4'h1;
    localparam logic [7:0] OPC_SWAP_DE = 8'hEB;
    localparam logic [7:0] OPC_SWAP_ST = 8'hE3;
    // opcode field positions
    localparam int FLD_PFX_HI  = 7;
    localparam int FLD_PFX_LO  = 6;
    localparam int FLD_OP_HI   = 5;
    localparam int FLD_OP_LO   = 3;
    localparam int FLD_SRC_HI  = 2;
    localparam int FLD_SRC_LO  = 0;
    localparam int FLD_PAIR_HI = 5;
    localparam int FLD_PAIR_LO = 4;
    localparam int FLD_LOW4_HI = 3;
    localparam int FLD_LOW4_LO = 0;
    // state counts
    localparam logic [4:0] CYC_ALU_REG = 5'h04;
    localparam logic [4:0] CYC_ALU_MEM = 5'h07;
    localparam logic [4:0] CYC_ALU_IMM = 5'h07;
    localparam logic [4:0] CYC_PLD     = 5'h0A;
    localparam logic [4:0] CYC_PUSH    = 5'h0B;
    localparam logic [4:0] CYC_POP     = 5'h0A;
    localparam logic [4:0] CYC_SWAP_DE = 5'h04;
    localparam logic [4:0] CYC_SWAP_ST = 5'h12;

    typedef enum logic [3:0] {
        COD_CLS_NONE,
        COD_CLS_ALU_REG,
        COD_CLS_ALU_MEM,
        COD_CLS_ALU_IMM,
        COD_CLS_PLD,
        COD_CLS_PUSH,
        COD_CLS_POP,
        COD_CLS_SWAP_DE,
        COD_CLS_SWAP_ST
    } cod_class_e;
endpackage : cod_pkg

// ---- hw/cod_decoder.sv ----
// Function
// RULE1: register accumulator ops decode, 4 cycles
// RULE2: source 110 is memory operand, 7 cycles
// RULE3: immediate accumulator ops, 7 cycles
// RULE4: carry added or borrowed only in variants
// RULE5: pair immediate load, 10 cycles
// RULE6: pair push, code 11 acc+flags, 11
// RULE7: pair pop, code 11 acc+flags, 10
// RULE8: swap_de_hl swaps DE and HL, 4
// RULE9: swap_stacktop_hl swaps HL with stack, 18
// RULE10: memory address from HL; compare flags only
// RULE11: register select codes B..L, A=111
`timescale 1ns/1ps
module cod_decoder (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       opc_valid,
    input  wire logic [7:0] opc_byte,
    input  wire logic       carry_in,
    output logic            dec_valid,
    output logic [3:0]      dec_class,
    output logic [2:0]      alu_op,
    output logic [2:0]      src_reg,
    output logic [1:0]      pair_sel,
    output logic            pair_acc_flg,
    output logic            addr_from_hl,
    output logic            write_acc,
    output logic            carry_use,
    output logic            carry_inv,
    output logic [4:0]      state_count,
    output logic            illegal
);
    typedef struct packed {
        logic                    valid;
        cod_pkg::cod_class_e     cls;
        logic [2:0]              op;
        logic [2:0]              src;
        logic [1:0]              pair;
        logic                    accf;
        logic                    hl_addr;
        logic                    wacc;
        logic                    cuse;
        logic                    cinv;
        logic [4:0]              cnt;
        logic                    bad;
    } cod_state_s;

    cod_state_s st_reg;
    cod_state_s st_next;

    logic [1:0] pfx;
    logic [2:0] fld_op;
    logic [2:0] fld_src;
    logic [1:0] fld_pair;
    logic [3:0] fld_low4;

    assign pfx      = opc_byte[cod_pkg::FLD_PFX_HI:cod_pkg::FLD_PFX_LO];
    assign fld_op   = opc_byte[cod_pkg::FLD_OP_HI:cod_pkg::FLD_OP_LO];
    assign fld_src  = opc_byte[cod_pkg::FLD_SRC_HI:cod_pkg::FLD_SRC_LO];
    assign fld_pair = opc_byte[cod_pkg::FLD_PAIR_HI:cod_pkg::FLD_PAIR_LO];
    assign fld_low4 = opc_byte[cod_pkg::FLD_LOW4_HI:cod_pkg::FLD_LOW4_LO];

    always_comb begin
        st_next       = '0;
        st_next.cls   = cod_pkg::COD_CLS_NONE;
        st_next.valid = opc_valid;
        if (opc_valid) begin
            if (pfx == cod_pkg::PFX_ALU_REG) begin
                st_next.op   = fld_op;                           // RULE1
                st_next.src  = fld_src;                          // RULE11
                st_next.wacc = (fld_op != cod_pkg::OP_CPA);      // RULE10
                if (fld_src == cod_pkg::REG_MEM) begin
                    st_next.cls     = cod_pkg::COD_CLS_ALU_MEM;  // RULE2
                    st_next.cnt     = cod_pkg::CYC_ALU_MEM;      // RULE2
                    st_next.hl_addr = 1'b1;                      // RULE10
                end else begin
                    st_next.cls = cod_pkg::COD_CLS_ALU_REG;      // RULE1
                    st_next.cnt = cod_pkg::CYC_ALU_REG;          // RULE1
                end
            end else if (pfx == cod_pkg::PFX_HI &&
                         fld_src == cod_pkg::LOW_IMM) begin
                st_next.cls  = cod_pkg::COD_CLS_ALU_IMM;         // RULE3
                st_next.op   = fld_op;                           // RULE3
                st_next.cnt  = cod_pkg::CYC_ALU_IMM;             // RULE3
                st_next.wacc = (fld_op != cod_pkg::OP_CPA);      // RULE10
            end else if (opc_byte == cod_pkg::OPC_SWAP_DE) begin
                st_next.cls = cod_pkg::COD_CLS_SWAP_DE;          // RULE8
                st_next.cnt = cod_pkg::CYC_SWAP_DE;              // RULE8
            end else if (opc_byte == cod_pkg::OPC_SWAP_ST) begin
                st_next.cls = cod_pkg::COD_CLS_SWAP_ST;          // RULE9
                st_next.cnt = cod_pkg::CYC_SWAP_ST;              // RULE9
            end else if (pfx == cod_pkg::PFX_HI &&
                         fld_low4 == cod_pkg::LOW_PUSH) begin
                st_next.cls  = cod_pkg::COD_CLS_PUSH;            // RULE6
                st_next.pair = fld_pair;                         // RULE6
                st_next.accf = (fld_pair == cod_pkg::PAIR_SP);   // RULE6
                st_next.cnt  = cod_pkg::CYC_PUSH;                // RULE6
            end else if (pfx == cod_pkg::PFX_HI &&
                         fld_low4 == cod_pkg::LOW_POP) begin
                st_next.cls  = cod_pkg::COD_CLS_POP;             // RULE7
                st_next.pair = fld_pair;                         // RULE7
                st_next.accf = (fld_pair == cod_pkg::PAIR_SP);   // RULE7
                st_next.cnt  = cod_pkg::CYC_POP;                 // RULE7
            end else if (pfx == cod_pkg::PFX_LO &&
                         fld_low4 == cod_pkg::LOW_PLD) begin
                st_next.cls  = cod_pkg::COD_CLS_PLD;             // RULE5
                st_next.pair = fld_pair;                         // RULE5
                st_next.cnt  = cod_pkg::CYC_PLD;                 // RULE5
            end else begin
                // other opcodes belong to another decoder stage
                st_next.bad = 1'b1;
            end
            // carry only matters for the two carry variants
            if ((st_next.cls == cod_pkg::COD_CLS_ALU_REG ||
                 st_next.cls == cod_pkg::COD_CLS_ALU_MEM ||
                 st_next.cls == cod_pkg::COD_CLS_ALU_IMM) &&
                (fld_op == cod_pkg::OP_ADC ||
                 fld_op == cod_pkg::OP_SBW)) begin
                st_next.cuse = carry_in;                          // RULE4
                st_next.cinv = (fld_op == cod_pkg::OP_SBW);       // RULE4
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st_reg     <= '0;
            st_reg.cls <= cod_pkg::COD_CLS_NONE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dec_valid    = st_reg.valid;
    assign dec_class    = st_reg.cls;
    assign alu_op       = st_reg.op;
    assign src_reg      = st_reg.src;
    assign pair_sel     = st_reg.pair;
    assign pair_acc_flg = st_reg.accf;
    assign addr_from_hl = st_reg.hl_addr;
    assign write_acc    = st_reg.wacc;
    assign carry_use    = st_reg.cuse;
    assign carry_inv    = st_reg.cinv;
    assign state_count  = st_reg.cnt;
    assign illegal      = st_reg.bad;

    logic alu_opc;

    // restated from the encoding so the checks do not lean on st_next
    assign alu_opc = (pfx == cod_pkg::PFX_ALU_REG) ||
                     (pfx == cod_pkg::PFX_HI && fld_src == cod_pkg::LOW_IMM);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_alu_reg_count: assert property ( // RULE1
        opc_valid && pfx == cod_pkg::PFX_ALU_REG &&
        fld_src != cod_pkg::REG_MEM
        |=> state_count == cod_pkg::CYC_ALU_REG &&
            alu_op == $past(fld_op))
        else $error("register alu op count wrong");
    a_alu_mem_count: assert property ( // RULE2
        opc_valid && pfx == cod_pkg::PFX_ALU_REG &&
        fld_src == cod_pkg::REG_MEM
        |=> state_count == cod_pkg::CYC_ALU_MEM && addr_from_hl)
        else $error("memory alu op count wrong");
    a_alu_imm_count: assert property ( // RULE3
        opc_valid && pfx == cod_pkg::PFX_HI && fld_src == cod_pkg::LOW_IMM
        |=> state_count == cod_pkg::CYC_ALU_IMM &&
            dec_class == cod_pkg::COD_CLS_ALU_IMM &&
            alu_op == $past(fld_op))
        else $error("immediate alu op decode wrong");
    a_carry_only_var: assert property ( // RULE4
        carry_use |-> alu_op == cod_pkg::OP_ADC || alu_op == cod_pkg::OP_SBW)
        else $error("carry used outside carry variants");
    a_carry_passes: assert property ( // RULE4
        opc_valid && alu_opc &&
        (fld_op == cod_pkg::OP_ADC || fld_op == cod_pkg::OP_SBW)
        |=> carry_use == $past(carry_in) &&
            carry_inv == ($past(fld_op) == cod_pkg::OP_SBW))
        else $error("carry variant lost the carry");
    a_pld_count: assert property ( // RULE5
        opc_valid && pfx == cod_pkg::PFX_LO &&
        fld_low4 == cod_pkg::LOW_PLD
        |=> state_count == cod_pkg::CYC_PLD &&
            pair_sel == $past(fld_pair))
        else $error("pair load decode wrong");
    a_push_count: assert property ( // RULE6
        opc_valid && pfx == cod_pkg::PFX_HI &&
        fld_low4 == cod_pkg::LOW_PUSH
        |=> state_count == cod_pkg::CYC_PUSH &&
            pair_acc_flg == ($past(fld_pair) == cod_pkg::PAIR_SP))
        else $error("push decode wrong");
    a_pop_count: assert property ( // RULE7
        opc_valid && pfx == cod_pkg::PFX_HI &&
        fld_low4 == cod_pkg::LOW_POP
        |=> state_count == cod_pkg::CYC_POP &&
            dec_class == cod_pkg::COD_CLS_POP)
        else $error("pop decode wrong");
    a_pop_acc_flags: assert property ( // RULE7
        opc_valid && pfx == cod_pkg::PFX_HI &&
        fld_low4 == cod_pkg::LOW_POP
        |=> pair_sel == $past(fld_pair) &&
            pair_acc_flg == ($past(fld_pair) == cod_pkg::PAIR_SP))
        else $error("pop pair select wrong");
    a_swap_de_count: assert property ( // RULE8
        opc_valid && opc_byte == cod_pkg::OPC_SWAP_DE
        |=> state_count == cod_pkg::CYC_SWAP_DE &&
            dec_class == cod_pkg::COD_CLS_SWAP_DE)
        else $error("swap_de_hl count wrong");
    a_swap_st_count: assert property ( // RULE9
        opc_valid && opc_byte == cod_pkg::OPC_SWAP_ST
        |=> state_count == cod_pkg::CYC_SWAP_ST &&
            dec_class == cod_pkg::COD_CLS_SWAP_ST)
        else $error("swap_stacktop_hl count wrong");
    a_cmp_no_write: assert property ( // RULE10
        dec_valid && alu_op == cod_pkg::OP_CPA &&
        dec_class inside {cod_pkg::COD_CLS_ALU_REG, cod_pkg::COD_CLS_ALU_MEM,
                          cod_pkg::COD_CLS_ALU_IMM}
        |-> !write_acc)
        else $error("compare wrote accumulator");
    a_alu_writes_acc: assert property ( // RULE10
        opc_valid && alu_opc && fld_op != cod_pkg::OP_CPA |=> write_acc)
        else $error("alu result not written to accumulator");
    a_hl_mem_only: assert property ( // RULE10
        dec_valid && dec_class != cod_pkg::COD_CLS_ALU_MEM |-> !addr_from_hl)
        else $error("hl address outside memory operand");
    a_src_select: assert property ( // RULE11
        opc_valid && pfx == cod_pkg::PFX_ALU_REG
        |=> src_reg == $past(fld_src))
        else $error("source register select wrong");

    c_alu_mem: cover property (
        dec_valid && dec_class == cod_pkg::COD_CLS_ALU_MEM);
    c_push_accf: cover property (
        dec_valid && pair_acc_flg && dec_class == cod_pkg::COD_CLS_PUSH);
    c_swap_st: cover property (
        dec_valid && dec_class == cod_pkg::COD_CLS_SWAP_ST);
    c_borrow: cover property (dec_valid && carry_use && carry_inv);
    c_pld: cover property (
        dec_valid && dec_class == cod_pkg::COD_CLS_PLD);
endmodule : cod_decoder

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin \
    n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp); end end
module tb_top;
    logic        ref_clk   = 1'b0;
    logic        resetn    = 1'b0;
    logic        opc_valid = 1'b0;
    logic [7:0]  opc_byte  = 8'h00;
    logic        carry_in  = 1'b0;
    logic        dec_valid;
    logic [3:0]  dec_class;
    logic [2:0]  alu_op;
    logic [2:0]  src_reg;
    logic [1:0]  pair_sel;
    logic        pair_acc_flg;
    logic        addr_from_hl;
    logic        write_acc;
    logic        carry_use;
    logic        carry_inv;
    logic [4:0]  state_count;
    logic        illegal;
    int          n_mismatch = 0;
    int          cmp_count  = 0;
    wire  [23:0] outv = {dec_valid, dec_class, alu_op, src_reg, pair_sel,
        pair_acc_flg, addr_from_hl, write_acc, carry_use, carry_inv,
        state_count, illegal};

    always #50 ref_clk = ~ref_clk;

    cod_decoder dut (.ref_clk(ref_clk), .resetn(resetn),
        .opc_valid(opc_valid), .opc_byte(opc_byte), .carry_in(carry_in),
        .dec_valid(dec_valid), .dec_class(dec_class), .alu_op(alu_op),
        .src_reg(src_reg), .pair_sel(pair_sel), .pair_acc_flg(pair_acc_flg),
        .addr_from_hl(addr_from_hl), .write_acc(write_acc),
        .carry_use(carry_use), .carry_inv(carry_inv),
        .state_count(state_count), .illegal(illegal));

    function automatic logic [23:0] exp_v(logic [3:0] cls, logic [2:0] op,
        logic [2:0] src, logic [1:0] pr, logic af, logic hl, logic wa,
        logic cu, logic ci, logic [4:0] cnt, logic ill);
        return {1'b1, cls, op, src, pr, af, hl, wa, cu, ci, cnt, ill};
    endfunction : exp_v

    // called at a falling edge; calls chain back to back every cycle
    task automatic send(logic [7:0] b, logic c, logic [23:0] e);
        opc_valid = 1'b1;
        opc_byte  = b;
        carry_in  = c;
        @(negedge ref_clk);
        `CHK(outv, e)
    endtask : send

    task automatic t_alu_reg();
        logic [2:0]  op;
        logic [2:0]  s;
        logic        m;
        logic [23:0] e;
        for (int i = 0; i < 64; i++) begin
            op = i[5:3];
            s  = i[2:0];
            m  = (s == 3'h6);
            e  = exp_v(m ? 4'h2 : 4'h1, op, s, 2'h0, 1'b0, m, op != 3'h7,
                s[0] & (op == 3'h1 || op == 3'h3), op == 3'h3,
                m ? 5'h07 : 5'h04, 1'b0);
            send({2'h2, op, s}, s[0], e);
        end
        $display("test alu_reg done");
    endtask : t_alu_reg

    task automatic t_alu_imm();
        logic [2:0] op;
        for (int i = 0; i < 8; i++) begin
            op = i[2:0];
            send({2'h3, op, 3'h6}, 1'b1, exp_v(4'h3, op, 3'h0, 2'h0, 1'b0,
                1'b0, op != 3'h7, op == 3'h1 || op == 3'h3, op == 3'h3,
                5'h07, 1'b0));
        end
        $display("test alu_imm done");
    endtask : t_alu_imm

    task automatic t_pairs();
        logic [1:0] p;
        for (int i = 0; i < 4; i++) begin
            p = i[1:0];
            send({2'h0, p, 4'h1}, 1'b1, exp_v(4'h4, 3'h0, 3'h0, p, 1'b0,
                1'b0, 1'b0, 1'b0, 1'b0, 5'h0A, 1'b0));
            send({2'h3, p, 4'h5}, 1'b0, exp_v(4'h5, 3'h0, 3'h0, p,
                p == 2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 5'h0B, 1'b0));
            send({2'h3, p, 4'h1}, 1'b1, exp_v(4'h6, 3'h0, 3'h0, p,
                p == 2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 5'h0A, 1'b0));
        end
        $display("test pairs done");
    endtask : t_pairs

    task automatic t_swaps();
        send(8'hEB, 1'b1, exp_v(4'h7, 3'h0, 3'h0, 2'h0, 1'b0, 1'b0, 1'b0,
            1'b0, 1'b0, 5'h04, 1'b0));
        send(8'hE3, 1'b1, exp_v(4'h8, 3'h0, 3'h0, 2'h0, 1'b0, 1'b0, 1'b0,
            1'b0, 1'b0, 5'h12, 1'b0));
        // outside the decoded set: flagged, no class and no count
        send(8'h00, 1'b1, exp_v(4'h0, 3'h0, 3'h0, 2'h0, 1'b0, 1'b0, 1'b0,
            1'b0, 1'b0, 5'h00, 1'b1));
        opc_valid = 1'b0;
        @(negedge ref_clk);
        `CHK(outv, 24'h000000)
        $display("test swaps done");
    endtask : t_swaps

    // reset dropped mid-stream, then an opcode at the first edge after it
    task automatic t_reset();
        logic [23:0] e;
        resetn    = 1'b0;
        opc_valid = 1'b1;
        opc_byte  = 8'h9E;
        carry_in  = 1'b1;
        @(negedge ref_clk);
        `CHK(outv, 24'h000000)
        resetn = 1'b1;
        e = exp_v(4'h2, 3'h3, 3'h6, 2'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1,
            5'h07, 1'b0);
        send(8'h9E, 1'b1, e);
        opc_valid = 1'b0;
        @(negedge ref_clk);
        `CHK(outv, 24'h000000)
        $display("test reset done");
    endtask : t_reset

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (2000) @(posedge ref_clk);
        n_mismatch++;
        stop_test();
    end

    initial begin
        repeat (12) @(negedge ref_clk);
        `CHK(outv, 24'h000000)
        resetn = 1'b1;
        t_alu_reg();
        t_alu_imm();
        t_pairs();
        t_swaps();
        t_reset();
        stop_test();
    end
endmodule : tb_top
